// ==== common/ifid_consts.svh ====
`ifndef IFID_CONSTS_SVH
`define IFID_CONSTS_SVH

// ----------------------------------------------------------------------
// Field positions (least significant bit of each 4-bit field)
// ----------------------------------------------------------------------
`define IFID_DOT_PRODUCT_LSB 6'h2C
`define IFID_BLOCK_CIPHER_LSB 6'h28
`define IFID_CHINESE_HASH_LSB 6'h24
`define IFID_KECCAK_HELPER_LSB 6'h20
`define IFID_ROUNDING_MAC_LSB 6'h1C
`define IFID_TRANS_MEMORY_LSB 6'h18
`define IFID_ATOMIC_LSB 6'h14

// ----------------------------------------------------------------------
// Field values
// ----------------------------------------------------------------------
`define IFID_DOT_PRODUCT_VAL 4'h1
`define IFID_BLOCK_CIPHER_VAL 4'h1
`define IFID_CHINESE_HASH_VAL 4'h1
`define IFID_KECCAK_HELPER_VAL 4'h1
`define IFID_ROUNDING_MAC_VAL 4'h1
`define IFID_TRANS_MEMORY_VAL 4'h0
`define IFID_ATOMIC_VAL 4'h2
`define IFID_FIELD_RESET 4'h0
`define IFID_REG_RESET 64'h0000_0000_0000_0000

// ----------------------------------------------------------------------
// System register encoding of the feature register
// ----------------------------------------------------------------------
`define IFID_ENC_OP0 2'h3
`define IFID_ENC_OP1 3'h0
`define IFID_ENC_CRN 4'h0
`define IFID_ENC_CRM 4'h6
`define IFID_ENC_OP2 3'h0

`endif

// ==== common/ifid_pkg.sv ====
package ifid_pkg;

  typedef logic [3:0] ifid_field_t;

  typedef enum logic [1:0] {
    IFID_ST_RESET,
    IFID_ST_CAPTURE,
    IFID_ST_RUN
  } ifid_state_t;

endpackage

// ==== src/ifid_field.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "ifid_consts.svh"

module ifid_field #(
  parameter ifid_pkg::ifid_field_t VALUE = 4'h0,
  parameter bit GATED = 1'b0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Load control
  input wire logic load,
  input wire logic cipher_on,
  // Field value
  output var ifid_pkg::ifid_field_t field_q
);

  // Gated fields collapse to zero when the cipher extension is off
  wire ifid_pkg::ifid_field_t field_d;
  assign field_d = (GATED && !cipher_on) ? `IFID_FIELD_RESET : VALUE;

  // Only the one load after reset changes the field
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      field_q <= `IFID_FIELD_RESET;
    end else if (load) begin
      field_q <= field_d;
    end
  end

endmodule

`default_nettype wire

// ==== src/ifid_top.sv ====
`timescale 1ns/1ps
`default_nettype none

`include "ifid_consts.svh"

module ifid_top #(
  parameter bit CIPHER_BUILD_OPTION = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Cluster strap
  input wire logic cipher_disable_input,
  // System register access
  input wire logic sysreg_rd_req,
  input wire logic sysreg_wr_req,
  input wire logic [1:0] sysreg_op0,
  input wire logic [2:0] sysreg_op1,
  input wire logic [3:0] sysreg_crn,
  input wire logic [3:0] sysreg_crm,
  input wire logic [2:0] sysreg_op2,
  output logic sysreg_ready_q,
  output logic sysreg_rd_ack_q,
  output logic sysreg_hit_q,
  output logic [63:0] sysreg_rd_data_q,
  // Cipher instruction check
  input wire logic cipher_insn_valid,
  output logic cipher_undef_q,
  output logic cipher_enabled_q
);

  // --------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // --------------------------------------------------------------------
  // Strap capture sequence
  // --------------------------------------------------------------------
  ifid_pkg::ifid_state_t state_q;
  ifid_pkg::ifid_state_t state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ifid_pkg::IFID_ST_RESET: begin
        state_d = ifid_pkg::IFID_ST_CAPTURE;
      end
      ifid_pkg::IFID_ST_CAPTURE: begin
        state_d = ifid_pkg::IFID_ST_RUN;
      end
      ifid_pkg::IFID_ST_RUN: begin
        state_d = ifid_pkg::IFID_ST_RUN;
      end
      default: begin
        state_d = ifid_pkg::IFID_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= ifid_pkg::IFID_ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  wire logic capture;
  wire logic running;
  assign capture = (state_q == ifid_pkg::IFID_ST_CAPTURE);
  assign running = (state_q == ifid_pkg::IFID_ST_RUN);

  wire logic cipher_on_d;
  assign cipher_on_d = CIPHER_BUILD_OPTION && !cipher_disable_input;

  // sampled once after release
  // Strap is caught by a clocked load, never by the async reset itself
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cipher_enabled_q <= 1'b0;
    end else if (capture) begin
      cipher_enabled_q <= cipher_on_d;
    end
  end

  // --------------------------------------------------------------------
  // Feature fields
  // --------------------------------------------------------------------
  wire ifid_pkg::ifid_field_t dot_product_support_field;
  wire ifid_pkg::ifid_field_t block_cipher_support_field;
  wire ifid_pkg::ifid_field_t chinese_hash_support_field;
  wire ifid_pkg::ifid_field_t keccak_helper_support_field;
  wire ifid_pkg::ifid_field_t rounding_doubling_mac_field;
  wire ifid_pkg::ifid_field_t transactional_memory_field;
  wire ifid_pkg::ifid_field_t atomic_ops_field;

  ifid_field #(
    .VALUE(`IFID_DOT_PRODUCT_VAL),
    .GATED(1'b0)
  ) u_dot (
    .clk_sys(clk_sys),
    .rst_n(rst_n_q),
    .load(capture),
    .cipher_on(cipher_on_d),
    .field_q(dot_product_support_field)
  );

  ifid_field #(
    .VALUE(`IFID_BLOCK_CIPHER_VAL),
    .GATED(1'b1)
  ) u_block (
    .clk_sys(clk_sys),
    .rst_n(rst_n_q),
    .load(capture),
    .cipher_on(cipher_on_d),
    .field_q(block_cipher_support_field)
  );

  ifid_field #(
    .VALUE(`IFID_CHINESE_HASH_VAL),
    .GATED(1'b1)
  ) u_hash (
    .clk_sys(clk_sys),
    .rst_n(rst_n_q),
    .load(capture),
    .cipher_on(cipher_on_d),
    .field_q(chinese_hash_support_field)
  );

  ifid_field #(
    .VALUE(`IFID_KECCAK_HELPER_VAL),
    .GATED(1'b1)
  ) u_keccak (
    .clk_sys(clk_sys),
    .rst_n(rst_n_q),
    .load(capture),
    .cipher_on(cipher_on_d),
    .field_q(keccak_helper_support_field)
  );

  ifid_field #(
    .VALUE(`IFID_ROUNDING_MAC_VAL),
    .GATED(1'b0)
  ) u_rdmac (
    .clk_sys(clk_sys),
    .rst_n(rst_n_q),
    .load(capture),
    .cipher_on(cipher_on_d),
    .field_q(rounding_doubling_mac_field)
  );

  ifid_field #(
    .VALUE(`IFID_TRANS_MEMORY_VAL),
    .GATED(1'b0)
  ) u_tmem (
    .clk_sys(clk_sys),
    .rst_n(rst_n_q),
    .load(capture),
    .cipher_on(cipher_on_d),
    .field_q(transactional_memory_field)
  );

  ifid_field #(
    .VALUE(`IFID_ATOMIC_VAL),
    .GATED(1'b0)
  ) u_atomic (
    .clk_sys(clk_sys),
    .rst_n(rst_n_q),
    .load(capture),
    .cipher_on(cipher_on_d),
    .field_q(atomic_ops_field)
  );

  // --------------------------------------------------------------------
  // Register image and read decode
  // --------------------------------------------------------------------
  // Bits outside the fields this block owns read as zero
  wire logic [63:0] id_image;
  assign id_image =
    (64'(dot_product_support_field) << `IFID_DOT_PRODUCT_LSB) |
    (64'(block_cipher_support_field) << `IFID_BLOCK_CIPHER_LSB) |
    (64'(chinese_hash_support_field) << `IFID_CHINESE_HASH_LSB) |
    (64'(keccak_helper_support_field) << `IFID_KECCAK_HELPER_LSB) |
    (64'(rounding_doubling_mac_field) << `IFID_ROUNDING_MAC_LSB) |
    (64'(transactional_memory_field) << `IFID_TRANS_MEMORY_LSB) |
    (64'(atomic_ops_field) << `IFID_ATOMIC_LSB);

  wire logic enc_match;
  assign enc_match = (sysreg_op0 == `IFID_ENC_OP0) &&
                     (sysreg_op1 == `IFID_ENC_OP1) &&
                     (sysreg_crn == `IFID_ENC_CRN) &&
                     (sysreg_crm == `IFID_ENC_CRM) &&
                     (sysreg_op2 == `IFID_ENC_OP2);

  // --------------------------------------------------------------------
  // Read take and next values
  // --------------------------------------------------------------------
  // only reads are taken
  // Writes never reach any storage, so they need no decode at all
  wire logic rd_take;
  assign rd_take = running && sysreg_rd_req && !sysreg_wr_req;

  wire logic [63:0] rd_data_d;
  assign rd_data_d = enc_match ? id_image : `IFID_REG_RESET;

  wire logic ready_d;
  wire logic rd_ack_d;
  wire logic hit_d;
  wire logic [63:0] rd_word_d;
  assign ready_d = (state_d == ifid_pkg::IFID_ST_RUN);
  assign rd_ack_d = rd_take;
  assign hit_d = rd_take && enc_match;
  assign rd_word_d = rd_take ? rd_data_d : `IFID_REG_RESET;

  // --------------------------------------------------------------------
  // Read response
  // --------------------------------------------------------------------
  // Ready follows the run state, so it never leads the read decode
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sysreg_ready_q <= 1'b0;
    end else begin
      sysreg_ready_q <= ready_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sysreg_rd_ack_q <= 1'b0;
    end else begin
      sysreg_rd_ack_q <= rd_ack_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sysreg_hit_q <= 1'b0;
    end else begin
      sysreg_hit_q <= hit_d;
    end
  end

  // Data drops to zero so a stale word never looks like an answer
  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sysreg_rd_data_q <= `IFID_REG_RESET;
    end else begin
      sysreg_rd_data_q <= rd_word_d;
    end
  end

  // --------------------------------------------------------------------
  // Cipher instruction gate
  // --------------------------------------------------------------------
  // undefined while disabled
  // Held undefined until the strap is captured, so nothing slips through
  wire logic undef_d;
  assign undef_d = cipher_insn_valid && !cipher_enabled_q;

  always_ff @(posedge clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cipher_undef_q <= 1'b0;
    end else begin
      cipher_undef_q <= undef_d;
    end
  end

endmodule

`default_nettype wire

// ==== verif/ifid_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------
// Read port and cipher gate checks
// ------------------------------------------
module ifid_props #(
  parameter bit CIPHER_BUILD_OPTION = 1'b1
) (
  // Clock, reset and strap
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic cipher_disable_input,
  // Register read port
  input wire logic sysreg_rd_req,
  input wire logic sysreg_wr_req,
  input wire logic sysreg_ready_q,
  input wire logic sysreg_rd_ack_q,
  input wire logic sysreg_hit_q,
  input wire logic [63:0] sysreg_rd_data_q,
  // Cipher gate
  input wire logic cipher_insn_valid,
  input wire logic cipher_undef_q,
  input wire logic cipher_enabled_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  wire logic hit_ack = sysreg_rd_ack_q && sysreg_hit_q;

  chk_read_answer: assert property (
    sysreg_ready_q && sysreg_rd_req && !sysreg_wr_req |=> sysreg_rd_ack_q)
    else $error("read not answered");
  chk_write_ignored: assert property (
    sysreg_wr_req |=> !sysreg_rd_ack_q) else $error("write answered");
  chk_early_refused: assert property (
    !sysreg_ready_q |=> !sysreg_rd_ack_q) else $error("read before ready");
  chk_dot_field: assert property (
    hit_ack |-> sysreg_rd_data_q[47:44] == 4'h1) else $error("dot field");
  chk_cipher_on: assert property (
    hit_ack && cipher_enabled_q |-> sysreg_rd_data_q[43:32] == 12'h111)
    else $error("cipher fields on");
  chk_cipher_off: assert property (
    hit_ack && !cipher_enabled_q |-> sysreg_rd_data_q[43:32] == 12'h000)
    else $error("cipher fields off");
  chk_fixed_fields: assert property (
    hit_ack |-> sysreg_rd_data_q[31:20] == 12'h102)
    else $error("fixed fields");
  chk_undef_pulse: assert property (
    cipher_insn_valid && !cipher_enabled_q |=> cipher_undef_q)
    else $error("undefined not raised");
  chk_undef_quiet: assert property (
    cipher_insn_valid && cipher_enabled_q |=> !cipher_undef_q)
    else $error("undefined raised");
  chk_enable_held: assert property (
    sysreg_ready_q && $past(sysreg_ready_q) |-> $stable(cipher_enabled_q))
    else $error("decision changed");
  chk_enable_capture: assert property (
    $rose(sysreg_ready_q) |->
      cipher_enabled_q == (CIPHER_BUILD_OPTION && !$past(cipher_disable_input)))
    else $error("decision wrong");
endmodule

bind ifid_top ifid_props #(.CIPHER_BUILD_OPTION(CIPHER_BUILD_OPTION)) u_props (
  .clk_sys, .arst_n, .cipher_disable_input, .sysreg_rd_req, .sysreg_wr_req,
  .sysreg_ready_q, .sysreg_rd_ack_q, .sysreg_hit_q, .sysreg_rd_data_q,
  .cipher_insn_valid, .cipher_undef_q, .cipher_enabled_q);
`default_nettype wire

// ==== verif/tb_isa_feature_id_fields.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_isa_feature_id_fields;
  localparam logic [15:0] FEAT = {2'h3, 3'h0, 4'h0, 4'h6, 3'h0};
  localparam logic [63:0] IMG_ON = 64'h0000_1111_1020_0000;
  localparam logic [63:0] IMG_OFF = 64'h0000_1000_1020_0000;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic dis = 1'b0;
  logic rd_req = 1'b0;
  logic wr_req = 1'b0;
  logic insn = 1'b0;
  logic [15:0] enc = 16'h0000;
  logic ready, ack, hit, undef, enabled;
  logic [63:0] data;
  int mismatches = 0;
  int compares = 0;

  always #12.5 clk_sys = ~clk_sys;

  ifid_top #(.CIPHER_BUILD_OPTION(1'b1)) DUT (
    .clk_sys(clk_sys), .arst_n(arst_n), .cipher_disable_input(dis),
    .sysreg_rd_req(rd_req), .sysreg_wr_req(wr_req),
    .sysreg_op0(enc[15:14]), .sysreg_op1(enc[13:11]),
    .sysreg_crn(enc[10:7]), .sysreg_crm(enc[6:3]), .sysreg_op2(enc[2:0]),
    .sysreg_ready_q(ready), .sysreg_rd_ack_q(ack), .sysreg_hit_q(hit),
    .sysreg_rd_data_q(data), .cipher_insn_valid(insn),
    .cipher_undef_q(undef), .cipher_enabled_q(enabled));

  // ------------------------------------------
  // Tasks, entered at a falling edge except the first boot at time 0 and a timed-out finish_test
  // ------------------------------------------
  task automatic finish_test();
    if (mismatches == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp,
                     input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Strap is held steady through the capture edge; a read is left
  // pending so that nothing may answer before ready
  task automatic boot(input logic d);
    arst_n = 1'b0;
    dis = d;
    rd_req = 1'b1;
    enc = FEAT;
    repeat (10) @(negedge clk_sys);
    arst_n = 1'b1;
    for (int i = 0; i < 20 && ready !== 1'b1; i++) begin
      @(negedge clk_sys);
      chk("early_ack_hit", 64'h0, 64'({ack, hit}));
    end
    chk("ready", 64'h1, 64'(ready));
  endtask

  // Request stays up so calls may run back to back
  task automatic rd(input logic [15:0] e, input logic w,
                    input logic [63:0] exp, input logic [1:0] ah);
    rd_req = 1'b1;
    wr_req = w;
    enc = e;
    @(negedge clk_sys);
    chk("ack_hit", 64'(ah), 64'({ack, hit}));
    chk("rd_data", exp, data);
  endtask

  task automatic idle();
    rd_req = 1'b0;
    wr_req = 1'b0;
    @(negedge clk_sys);
    chk("idle_data", 64'h0, data);
    chk("idle_ack_hit", 64'h0, 64'({ack, hit}));
  endtask

  task automatic gate(input logic exp);
    insn = 1'b1;
    @(negedge clk_sys);
    insn = 1'b0;
    chk("undef", 64'(exp), 64'(undef));
  endtask

  // ------------------------------------------
  // Main sequence
  // ------------------------------------------
  initial begin
    boot(1'b0);
    chk("enabled", 64'h1, 64'(enabled));
    rd(FEAT, 1'b0, IMG_ON, 2'h3);
    rd(FEAT, 1'b0, IMG_ON, 2'h3);
    rd(FEAT, 1'b1, 64'h0, 2'h0);
    for (int i = 0; i < 16; i++) begin
      rd(FEAT ^ (16'h1 << i), 1'b0, 64'h0, 2'h2);
    end
    idle();
    dis = 1'b1;
    gate(1'b0);
    rd(FEAT, 1'b0, IMG_ON, 2'h3);
    idle();
    boot(1'b1);
    chk("enabled", 64'h0, 64'(enabled));
    rd(FEAT, 1'b0, IMG_OFF, 2'h3);
    idle();
    dis = 1'b0;
    gate(1'b1);
    rd(FEAT, 1'b0, IMG_OFF, 2'h3);
    idle();
    finish_test();
  end

  // Whole run is near 56 cycles
  initial begin
    repeat (2000) @(posedge clk_sys);
    mismatches++;
    finish_test();
  end
endmodule
`default_nettype wire
